/* File: logic/dmia_pkg.sv */
package dmia_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 256;
  // special purpose addresses
  localparam logic [7:0] ADDR_IAP0 = 8'h00;
  localparam logic [7:0] ADDR_PTR0 = 8'h01;
  localparam logic [7:0] ADDR_IAP1 = 8'h02;
  localparam logic [7:0] ADDR_PTR1 = 8'h03;
  localparam logic [7:0] ADDR_GAP_A = 8'h04;
  localparam logic [7:0] ADDR_WORK = 8'h05;
  localparam logic [7:0] ADDR_PC_LOW = 8'h06;
  localparam logic [7:0] ADDR_TABLE_PTR = 8'h07;
  localparam logic [7:0] ADDR_TABLE_HIGH = 8'h08;
  localparam logic [7:0] ADDR_WDOG_DIV = 8'h09;
  localparam logic [7:0] ADDR_STATUS = 8'h0a;
  localparam logic [7:0] ADDR_INT_CTRL0 = 8'h0b;
  localparam logic [7:0] ADDR_GAP_B = 8'h0c;
  localparam logic [7:0] ADDR_TIMER0_COUNT = 8'h0d;
  localparam logic [7:0] ADDR_TIMER0_CTRL = 8'h0e;
  localparam logic [7:0] ADDR_TIMER1_HIGH = 8'h0f;
  localparam logic [7:0] ADDR_TIMER1_LOW = 8'h10;
  localparam logic [7:0] ADDR_TIMER1_CTRL = 8'h11;
  localparam logic [7:0] ADDR_PORTA_DATA = 8'h12;
  localparam logic [7:0] ADDR_PORTA_DIR = 8'h13;
  localparam logic [7:0] ADDR_PORTB_DATA = 8'h14;
  localparam logic [7:0] ADDR_PORTB_DIR = 8'h15;
  localparam logic [7:0] ADDR_PORTC_DATA = 8'h16;
  localparam logic [7:0] ADDR_PORTC_DIR = 8'h17;
  localparam logic [7:0] ADDR_PORTD_DATA = 8'h18;
  localparam logic [7:0] ADDR_PORTD_DIR = 8'h19;
  localparam logic [7:0] ADDR_PW0_HIGH = 8'h1a;
  localparam logic [7:0] ADDR_PW0_LOW = 8'h1b;
  localparam logic [7:0] ADDR_PW_CTRL0 = 8'h1c;
  localparam logic [7:0] ADDR_PW_CTRL1 = 8'h1d;
  localparam logic [7:0] ADDR_INT_CTRL1 = 8'h1e;
  localparam logic [7:0] ADDR_MF_INT_CTRL = 8'h1f;
  localparam logic [7:0] ADDR_CONV_LOW = 8'h20;
  localparam logic [7:0] ADDR_CONV_HIGH = 8'h21;
  localparam logic [7:0] ADDR_CONV_CTRL = 8'h22;
  localparam logic [7:0] ADDR_CONV_CLK = 8'h23;
  localparam logic [7:0] ADDR_CMP_CTRL = 8'h24;
  localparam logic [7:0] ADDR_AUX = 8'h25;
  localparam logic [7:0] ADDR_OPAMP_CTRL = 8'h26;
  localparam logic [7:0] ADDR_DEBOUNCE = 8'h27;
  localparam logic [7:0] ADDR_PW1_HIGH = 8'h2a;
  localparam logic [7:0] ADDR_PW1_LOW = 8'h2b;
  localparam logic [7:0] ADDR_PW2_HIGH = 8'h2c;
  localparam logic [7:0] ADDR_PW2_LOW = 8'h2d;
  localparam logic [7:0] ADDR_PAIR_CTRL = 8'h2e;
  localparam logic [7:0] ADDR_PAIR_SET = 8'h2f;
  localparam logic [7:0] ADDR_LVD_CTRL = 8'h30;
  localparam logic [7:0] ADDR_GAP_C = 8'h28;
  localparam logic [7:0] ADDR_GAP_D = 8'h29;
  localparam logic [7:0] ADDR_SPR_LAST = 8'h31;
  // general purpose start (parameterised, default right after last special register)
  localparam logic [7:0] GP_START_DEF = 8'h32;
  localparam logic [7:0] GP_LAST_DEF = 8'hf1;
  // status bits that writes cannot change (power down, time-out)
  localparam logic [7:0] STATUS_RO_MASK = 8'h30;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ALL_BITS = 8'hff;
  // operation codes
  typedef enum logic [2:0] {
    DMIA_OP_NONE = 3'h0,
    DMIA_OP_READ = 3'h1,
    DMIA_OP_WRITE = 3'h2,
    DMIA_OP_BSET = 3'h3,
    DMIA_OP_BCLR = 3'h4,
    DMIA_OP_ALU = 3'h5,
    DMIA_OP_LOADW = 3'h6,
    DMIA_OP_STOREW = 3'h7
  } dmia_op_t;
  typedef struct packed {
    dmia_op_t op;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [2:0] bit_sel;
  } dmia_req_t;
  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] work;
    logic [7:0] ptr0;
    logic [7:0] ptr1;
    logic done;
  } dmia_state_t;
endpackage

/* File: logic/dmia_top.sv */
// Summary of operation
// RULE_01 - every location holds exactly eight bits
// RULE_02 - address space starts at zero
// RULE_03 - special and general areas are contiguous
// RULE_04 - unused special addresses read as zero
// RULE_05 - general RAM reads, writes, retains bytes
// RULE_06 - read-only special registers ignore writes
// RULE_07 - bit set/clear except dedicated bits
// RULE_08 - indirect ports act on pointed location
// RULE_09 - pointers are real read/write registers
// RULE_10 - pointer at port: read zero, write nothing
// RULE_11 - register moves go via working register
// RULE_12 - working register captures ALU results
// RULE_13 - accesses complete in one clock cycle
// RULE_14 - bit ops read-modify-write, also indirect
module dmia_top import dmia_pkg::*; #(
  parameter logic [7:0] GP_START = GP_START_DEF,
  parameter logic [7:0] GP_LAST = GP_LAST_DEF
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire dmia_req_t REQ,
  input wire logic [7:0] ALU_RESULT,
  input wire logic [7:0] TABLE_HIGH_LOAD,
  input wire logic TABLE_HIGH_LOAD_EN,
  input wire logic [7:0] STATUS_HW,
  input wire logic [7:0] STATUS_HW_MASK,
  output logic [7:0] RDATA,
  output logic [7:0] WORK_REG,
  output logic [7:0] PTR0,
  output logic [7:0] PTR1,
  output logic DONE
);

  // storage array, one byte per address
  logic [7:0] mem [0:MEM_DEPTH-1]; // RULE_01
  dmia_state_t st_reg;
  dmia_state_t st_next;
  logic [7:0] eff_addr;
  logic indirect_hit;
  logic port_target;
  logic mapped;
  logic [7:0] cur_byte;
  logic [7:0] new_byte;
  logic do_store;
  logic [7:0] bit_mask;
  logic [7:0] keep;

  // true for the two virtual port addresses
  function automatic logic is_port(input logic [7:0] a);
    is_port = (a == ADDR_IAP0) || (a == ADDR_IAP1);
  endfunction

  // true for special addresses that hold a register
  function automatic logic spr_present(input logic [7:0] a);
    spr_present = 1'b0;
    case (a)
      // pointers and working register
      ADDR_PTR0: begin
        spr_present = 1'b1;
      end
      ADDR_PTR1: begin
        spr_present = 1'b1;
      end
      ADDR_WORK: begin
        spr_present = 1'b1;
      end
      // program flow, table access, watchdog, status and interrupt control
      ADDR_PC_LOW: begin
        spr_present = 1'b1;
      end
      ADDR_TABLE_PTR: begin
        spr_present = 1'b1;
      end
      ADDR_TABLE_HIGH: begin
        spr_present = 1'b1;
      end
      ADDR_WDOG_DIV: begin
        spr_present = 1'b1;
      end
      ADDR_STATUS: begin
        spr_present = 1'b1;
      end
      ADDR_INT_CTRL0: begin
        spr_present = 1'b1;
      end
      // timers
      ADDR_TIMER0_COUNT: begin
        spr_present = 1'b1;
      end
      ADDR_TIMER0_CTRL: begin
        spr_present = 1'b1;
      end
      ADDR_TIMER1_HIGH: begin
        spr_present = 1'b1;
      end
      ADDR_TIMER1_LOW: begin
        spr_present = 1'b1;
      end
      ADDR_TIMER1_CTRL: begin
        spr_present = 1'b1;
      end
      // port data and direction
      ADDR_PORTA_DATA: begin
        spr_present = 1'b1;
      end
      ADDR_PORTA_DIR: begin
        spr_present = 1'b1;
      end
      ADDR_PORTB_DATA: begin
        spr_present = 1'b1;
      end
      ADDR_PORTB_DIR: begin
        spr_present = 1'b1;
      end
      ADDR_PORTC_DATA: begin
        spr_present = 1'b1;
      end
      ADDR_PORTC_DIR: begin
        spr_present = 1'b1;
      end
      ADDR_PORTD_DATA: begin
        spr_present = 1'b1;
      end
      ADDR_PORTD_DIR: begin
        spr_present = 1'b1;
      end
      // first pulse width channel and interrupt control
      ADDR_PW0_HIGH: begin
        spr_present = 1'b1;
      end
      ADDR_PW0_LOW: begin
        spr_present = 1'b1;
      end
      ADDR_PW_CTRL0: begin
        spr_present = 1'b1;
      end
      ADDR_PW_CTRL1: begin
        spr_present = 1'b1;
      end
      ADDR_INT_CTRL1: begin
        spr_present = 1'b1;
      end
      ADDR_MF_INT_CTRL: begin
        spr_present = 1'b1;
      end
      // converter and analog settings
      ADDR_CONV_LOW: begin
        spr_present = 1'b1;
      end
      ADDR_CONV_HIGH: begin
        spr_present = 1'b1;
      end
      ADDR_CONV_CTRL: begin
        spr_present = 1'b1;
      end
      ADDR_CONV_CLK: begin
        spr_present = 1'b1;
      end
      ADDR_CMP_CTRL: begin
        spr_present = 1'b1;
      end
      ADDR_AUX: begin
        spr_present = 1'b1;
      end
      ADDR_OPAMP_CTRL: begin
        spr_present = 1'b1;
      end
      ADDR_DEBOUNCE: begin
        spr_present = 1'b1;
      end
      // remaining pulse width channels
      ADDR_PW1_HIGH: begin
        spr_present = 1'b1;
      end
      ADDR_PW1_LOW: begin
        spr_present = 1'b1;
      end
      ADDR_PW2_HIGH: begin
        spr_present = 1'b1;
      end
      ADDR_PW2_LOW: begin
        spr_present = 1'b1;
      end
      ADDR_PAIR_CTRL: begin
        spr_present = 1'b1;
      end
      ADDR_PAIR_SET: begin
        spr_present = 1'b1;
      end
      // supply monitor and last special register
      ADDR_LVD_CTRL: begin
        spr_present = 1'b1;
      end
      ADDR_SPR_LAST: begin
        spr_present = 1'b1;
      end
      // ports are virtual, gaps are unused
      default: begin
        spr_present = 1'b0; // RULE_04
      end
    endcase
  endfunction

  // true for addresses that hold storage
  function automatic logic is_mapped(input logic [7:0] a);
    if (a <= ADDR_SPR_LAST) begin
      is_mapped = spr_present(a); // RULE_04
    end else begin
      is_mapped = (a >= GP_START) && (a <= GP_LAST); // RULE_03
    end
  endfunction

  // bits that program writes and bit ops leave alone
  function automatic logic [7:0] keep_mask(input logic [7:0] a);
    case (a)
      ADDR_TABLE_HIGH: begin
        keep_mask = ALL_BITS; // RULE_06
      end
      ADDR_STATUS: begin
        keep_mask = STATUS_RO_MASK; // RULE_06 RULE_07
      end
      default: begin
        keep_mask = ZERO_BYTE;
      end
    endcase
  endfunction

  // addresses whose byte lives in the state struct, not the array
  function automatic logic held_in_state(input logic [7:0] a);
    case (a)
      ADDR_PTR0: begin
        held_in_state = 1'b1; // RULE_09
      end
      ADDR_PTR1: begin
        held_in_state = 1'b1; // RULE_09
      end
      ADDR_WORK: begin
        held_in_state = 1'b1; // RULE_11
      end
      default: begin
        held_in_state = 1'b0;
      end
    endcase
  endfunction

  // redirect port addresses through their pointer
  always_comb begin
    indirect_hit = is_port(REQ.addr);
    if (REQ.addr == ADDR_IAP0) begin
      eff_addr = st_reg.ptr0; // RULE_08
    end else if (REQ.addr == ADDR_IAP1) begin
      eff_addr = st_reg.ptr1; // RULE_08
    end else begin
      eff_addr = REQ.addr; // RULE_02
    end
    port_target = indirect_hit && is_port(eff_addr); // RULE_10
    mapped = is_mapped(eff_addr) && !port_target;
  end

  // current byte of the addressed location
  always_comb begin
    if (!mapped) begin
      cur_byte = ZERO_BYTE; // RULE_04 RULE_10
    end else if (eff_addr == ADDR_PTR0) begin
      cur_byte = st_reg.ptr0; // RULE_09
    end else if (eff_addr == ADDR_PTR1) begin
      cur_byte = st_reg.ptr1; // RULE_09
    end else if (eff_addr == ADDR_WORK) begin
      cur_byte = st_reg.work;
    end else begin
      cur_byte = mem[eff_addr];
    end
  end

  // build the byte to store, bit ops read-modify-write
  always_comb begin
    bit_mask = 8'h01 << REQ.bit_sel;
    do_store = 1'b0;
    new_byte = cur_byte;
    case (REQ.op)
      DMIA_OP_WRITE: begin
        new_byte = REQ.wdata;
        do_store = 1'b1;
      end
      DMIA_OP_STOREW: begin
        new_byte = st_reg.work; // RULE_11
        do_store = 1'b1;
      end
      DMIA_OP_BSET: begin
        new_byte = cur_byte | bit_mask; // RULE_07 RULE_14
        do_store = 1'b1;
      end
      DMIA_OP_BCLR: begin
        new_byte = cur_byte & ~bit_mask; // RULE_07 RULE_14
        do_store = 1'b1;
      end
      default: begin
        do_store = 1'b0;
      end
    endcase
    // protected bits keep their value
    keep = keep_mask(eff_addr);
    new_byte = (new_byte & ~keep) | (cur_byte & keep); // RULE_06 RULE_07
    if (keep == ALL_BITS) begin
      do_store = 1'b0; // RULE_06
    end
    if (!mapped) begin
      do_store = 1'b0; // RULE_10
    end
  end

  // next state of registers and answer
  always_comb begin
    st_next = st_reg;
    st_next.done = (REQ.op != DMIA_OP_NONE); // RULE_13
    st_next.rdata = cur_byte;
    if (do_store && eff_addr == ADDR_PTR0) begin
      st_next.ptr0 = new_byte; // RULE_09
    end
    if (do_store && eff_addr == ADDR_PTR1) begin
      st_next.ptr1 = new_byte; // RULE_09
    end
    if (do_store && eff_addr == ADDR_WORK) begin
      st_next.work = new_byte;
    end
    case (REQ.op)
      DMIA_OP_ALU: begin
        st_next.work = ALU_RESULT; // RULE_12
      end
      DMIA_OP_LOADW: begin
        st_next.work = cur_byte; // RULE_11
      end
      default: begin
      end
    endcase
  end

  // state register
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next; // RULE_13
    end
  end

  // byte array writes, plus hardware updates of status and table high byte
  always_ff @(posedge SYS_CLK) begin
    if (do_store && !held_in_state(eff_addr)) begin
      mem[eff_addr] <= new_byte; // RULE_05 RULE_13
    end
    if (TABLE_HIGH_LOAD_EN) begin
      mem[ADDR_TABLE_HIGH] <= TABLE_HIGH_LOAD;
    end
    if (|STATUS_HW_MASK) begin
      mem[ADDR_STATUS] <= (STATUS_HW & STATUS_HW_MASK) |
        ((do_store && eff_addr == ADDR_STATUS ? new_byte : mem[ADDR_STATUS]) & ~STATUS_HW_MASK);
    end
  end

  assign RDATA = st_reg.rdata;
  assign WORK_REG = st_reg.work;
  assign PTR0 = st_reg.ptr0;
  assign PTR1 = st_reg.ptr1;
  assign DONE = st_reg.done;

endmodule

/* File: tb/dmia_monitor.sv */
module dmia_monitor import dmia_pkg::*; (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire dmia_req_t REQ,
  input wire logic [7:0] RDATA,
  input wire logic [7:0] WORK_REG,
  input wire logic [7:0] PTR0,
  input wire logic DONE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  // request decode
  wire logic go = REQ.op != DMIA_OP_NONE;
  wire logic rd = REQ.op == DMIA_OP_READ;
  // completion, register and read-back relations
  a_done_set: assert property (go |=> DONE)
    else $error("done");
  a_done_clr: assert property (!go |=> !DONE)
    else $error("done");
  a_hold_idle: assert property (!go |=> $stable(WORK_REG) && $stable(PTR0))
    else $error("hold");
  a_ptr_load: assert property (REQ.op == DMIA_OP_WRITE && REQ.addr == ADDR_PTR0
    |=> PTR0 == $past(REQ.wdata)) else $error("ptr");
  a_gap_zero: assert property (rd && REQ.addr == ADDR_GAP_A |=> RDATA == 8'h00)
    else $error("gap");
  a_work_read: assert property (rd && REQ.addr == ADDR_WORK
    |=> RDATA == $past(WORK_REG)) else $error("work");
  a_ptr_read: assert property (rd && REQ.addr == ADDR_PTR0
    |=> RDATA == $past(PTR0)) else $error("ptr");
  a_self_zero: assert property (rd && REQ.addr == ADDR_IAP0 && PTR0 == ADDR_IAP0
    |=> RDATA == 8'h00) else $error("self");
  // main scenarios seen
  c_bit_set: cover property (REQ.op == DMIA_OP_BSET);
  c_indirect: cover property (rd && REQ.addr == ADDR_IAP1);
  c_store: cover property (REQ.op == DMIA_OP_STOREW);
endmodule
bind dmia_top dmia_monitor mon (.SYS_CLK(SYS_CLK), .RST(RST), .REQ(REQ), .RDATA(RDATA),
  .WORK_REG(WORK_REG), .PTR0(PTR0), .DONE(DONE));

/* File: tb/dmia_core_model.sv */
module dmia_core_model import dmia_pkg::*; (
  input wire logic clk,
  output dmia_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // one request, launched just after an edge
  task automatic issue(dmia_op_t c, logic [7:0] a, d, logic [2:0] b);
    @(posedge clk) req <= '{c, a, d, b};
  endtask
endmodule

/* File: tb/testbench.sv */
module testbench import dmia_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, tle = 0, done, ed = 0, ok;
  logic [7:0] tl = '0, sh = '0, shm = '0, alu = '0, rdata, work, p0, p1, er, e;
  logic [7:0] m [256] = '{default: 8'hxx};
  int error_cnt = 0, comparisons = 0;
  dmia_req_t req;
  dmia_core_model core (.clk(clk), .req(req));
  dmia_top dut (.SYS_CLK(clk), .RST(rst), .REQ(req), .ALU_RESULT(alu), .TABLE_HIGH_LOAD(tl),
    .TABLE_HIGH_LOAD_EN(tle), .STATUS_HW(sh), .STATUS_HW_MASK(shm), .RDATA(rdata),
    .WORK_REG(work), .PTR0(p0), .PTR1(p1), .DONE(done));
  // clock and hang guard
  initial forever #20 clk = ~clk;
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    results();
  end
  task automatic chk(string n, logic [24:0] s, x);
    comparisons++;
    if (s !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, x, s);
    end
  endtask
  // issue a request, judge the previous one, step the model
  task automatic op(dmia_op_t c, logic [7:0] a, d, logic [2:0] b);
    core.issue(c, a, d, b);
    alu <= d;
    #1;
    if (ed) chk("rdata", {17'h0, rdata}, {17'h0, er});
    chk("outs", {done, work, p0, p1}, {ed, m[5], m[1], m[3]});
    e = a == 8'h00 ? m[1] : a == 8'h02 ? m[3] : a;
    ok = !(e inside {8'h00, 8'h02, 8'h04, 8'h0c, 8'h28, 8'h29}) && e < 8'hf2;
    er = ok ? m[e] : 8'h00;
    ed = c != DMIA_OP_NONE;
    case (c)
      DMIA_OP_BSET: d = er | 8'h01 << b;
      DMIA_OP_BCLR: d = er & ~(8'h01 << b);
      DMIA_OP_STOREW: d = m[5];
      DMIA_OP_ALU: m[5] = d;
      DMIA_OP_LOADW: m[5] = er;
      default: ;
    endcase
    if (ok && e != 8'h08 && c inside {[2:4], 7})
      m[e] = e == 8'h0a ? d & 8'hcf | m[e] & 8'h30 : d;
  endtask
  // reset, hardware loads, fill, then random traffic
  initial begin
    void'($urandom(32'h48f6c027));
    repeat (5) @(posedge clk);
    rst <= 0;
    @(posedge clk) {tle, tl, sh, shm} <= 25'h19c30ff;
    @(posedge clk) {tle, shm} <= 9'h0;
    m[8] = 8'h9c;
    m[10] = 8'h30;
    {m[1], m[3], m[5]} = 24'h0;
    op(DMIA_OP_READ, 8'h00, 8'h00, 3'h0);
    for (int i = 0; i < 256; i++) op(DMIA_OP_WRITE, 8'(i), 8'($urandom), 3'h0);
    repeat (2000) begin
      e = 8'($urandom) & ($urandom % 2 ? 8'h0f : 8'hff);
      op(dmia_op_t'(3'($urandom)), e, 8'($urandom), 3'($urandom));
    end
    op(DMIA_OP_NONE, 8'h00, 8'h00, 3'h0);
    results();
  end
  task automatic results();
    $display("errors %0d of %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
endmodule
